// ### thw_sensor_regs.sv
// Behaviour
// - settings bits 7:5 reserved, reset to zero; controller writes zeros
// - settings bits 4:3 select consecutive faults 1, 2, 4 or 6; reset 00
// - settings bit 2 set makes alert active high; reset active low
// - settings bit 1 set selects interrupt mode; reset comparator mode
// - settings bit 0 set means shutdown; reset normal operation
// - temperature register read-only, loaded at each conversion end
// - temperature is 11-bit two's complement, top of the 16-bit word
// - low five bits of temperature second byte read as zero
// - temperature read supplies both bytes, most significant first
// - a read ending after the first byte causes no malfunction
// - set-points are 9-bit two's complement, read/write, top of word
// - low seven bits of set-point second byte read as zero
// - comparison uses only the upper nine temperature bits
// - each conversion result is compared with both set-points
// - comparator mode: set above threshold, clear below hysteresis only
// - interrupt mode: alert holds until any register read clears it
// - alert changes only after the programmed run of trips
// - interrupt mode trips alternate between threshold and hysteresis
// - shutdown stops conversions; clears alert only in interrupt mode
// - threshold resets to 5000h, hysteresis to 4B00h
module thw_sensor_regs
  import thw_pkg::*;
(
  // core clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        core_ce,
  // converter side
  input  wire logic        conv_done_i,
  input  wire logic [10:0] conv_data_i,
  output logic             conv_enable_o,
  // link side register access
  input  wire logic        link_clk,
  input  wire logic        link_req_valid,
  input  thw_req_s         link_req,
  output logic             link_req_ready,
  output logic             link_rsp_valid,
  output logic [15:0]      link_rsp_data,
  // open-drain alert pin
  input  wire logic        alert_output_i,
  output logic             alert_output_o,
  output logic             alert_output_oe_n
);
  // ****************************************
  // link domain
  // ****************************************
  thw_link_e   state_reg;
  thw_req_s    req_hold_reg;
  logic        req_tgl_reg;
  logic [15:0] rsp_data_reg;
  logic        ack_pulse;
  logic        ack_tgl_reg;
  logic [15:0] rdata_reg;

  thw_toggle_sync u_ack_sync (
    .clk     (link_clk),
    .reset_n (reset_n),
    .ce      (1'b1),
    .tgl_i   (ack_tgl_reg),
    .pulse_o (ack_pulse)
  );

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= LNK_IDLE;
    end else begin
      case (state_reg)
        LNK_IDLE: if (link_req_valid) state_reg <= LNK_WAIT;
        LNK_WAIT: if (ack_pulse) state_reg <= LNK_DONE;
        default:  state_reg <= LNK_IDLE;
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_hold_reg <= '0;
      req_tgl_reg  <= 1'b0;
    end else if (state_reg == LNK_IDLE && link_req_valid) begin
      req_hold_reg <= link_req;
      req_tgl_reg  <= ~req_tgl_reg;
    end
  end

  // answer word is stable in the core while the ack crosses
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_data_reg <= 16'h0000;
    end else if (state_reg == LNK_WAIT && ack_pulse) begin
      rsp_data_reg <= rdata_reg;
    end
  end

  assign link_req_ready = (state_reg == LNK_IDLE);
  assign link_rsp_valid = (state_reg == LNK_DONE);
  assign link_rsp_data  = rsp_data_reg;

  // ****************************************
  // core domain: request decode
  // ****************************************
  logic                   req_pulse;
  logic                   core_do;
  logic                   rd_access;
  logic                   conf_wr;
  thw_conf_s              conf_reg;
  thw_conf_s              conf_new;
  logic [TEMP_W-1:0]      temp_reg;
  logic signed [LIM_W-1:0] over_reg;
  logic signed [LIM_W-1:0] hyst_reg;

  thw_toggle_sync u_req_sync (
    .clk     (core_clk),
    .reset_n (reset_n),
    .ce      (core_ce),
    .tgl_i   (req_tgl_reg),
    .pulse_o (req_pulse)
  );

  assign core_do   = core_ce && req_pulse;
  assign rd_access = core_do && !req_hold_reg.write;
  assign conf_wr   = core_do && req_hold_reg.write && req_hold_reg.sel == SEL_CONF;
  assign conf_new  = thw_conf_s'(req_hold_reg.wdata[15:CONF_PAD_W]);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      conf_reg <= thw_conf_s'(CONF_RST);
      over_reg <= OVER_RST[15:LIM_PAD_W];
      hyst_reg <= HYST_RST[15:LIM_PAD_W];
    end else if (core_do && req_hold_reg.write) begin
      if (req_hold_reg.sel == SEL_CONF) begin
        conf_reg <= conf_new;
      end else if (req_hold_reg.sel == SEL_HYST) begin
        hyst_reg <= req_hold_reg.wdata[15:LIM_PAD_W];
      end else if (req_hold_reg.sel == SEL_OVER) begin
        over_reg <= req_hold_reg.wdata[15:LIM_PAD_W];
      end
    end
  end

  // single or double byte read alike: only the word is latched
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg   <= 16'h0000;
      ack_tgl_reg <= 1'b0;
    end else if (core_do) begin
      ack_tgl_reg <= ~ack_tgl_reg;
      if (req_hold_reg.sel == SEL_TEMP) begin
        rdata_reg <= {temp_reg, TEMP_PAD_W'(0)};
      end else if (req_hold_reg.sel == SEL_CONF) begin
        rdata_reg <= {conf_reg, CONF_PAD_W'(0)};
      end else if (req_hold_reg.sel == SEL_HYST) begin
        rdata_reg <= {hyst_reg, LIM_PAD_W'(0)};
      end else begin
        rdata_reg <= {over_reg, LIM_PAD_W'(0)};
      end
    end
  end

  // ****************************************
  // core domain: conversion and compare
  // ****************************************
  logic                    conv_take;
  logic signed [LIM_W-1:0] t9_new;
  logic                    over_hit;
  logic                    under_hit;
  logic                    trip;
  logic                    fire;
  logic                    mode_change;
  logic                    shdn_set;
  logic [CNT_W-1:0]        fault_cnt_reg;
  logic [CNT_W-1:0]        cnt_inc;
  logic [CNT_W-1:0]        fq_target;
  logic                    alert_active_reg;
  logic                    expect_over_reg;

  assign conv_enable_o = !conf_reg.power_down_select;
  assign conv_take     = core_ce && conv_done_i && !conf_reg.power_down_select;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      temp_reg <= TEMP_RST;
    end else if (conv_take) begin
      temp_reg <= conv_data_i;
    end
  end

  assign t9_new    = conv_data_i[TEMP_W-1:CMP_DROP];
  assign over_hit  = t9_new > over_reg;
  assign under_hit = t9_new < hyst_reg;

  always_comb begin
    if (conf_reg.alert_mode_select) begin
      trip = !alert_active_reg && (expect_over_reg ? over_hit : under_hit);
    end else begin
      trip = alert_active_reg ? under_hit : over_hit;
    end
  end

  always_comb begin
    case (conf_reg.fault_count_select)
      FQ_CODE1: fq_target = FQ_CNT1;
      FQ_CODE2: fq_target = FQ_CNT2;
      FQ_CODE4: fq_target = FQ_CNT4;
      default:  fq_target = FQ_CNT6;
    endcase
  end

  assign cnt_inc     = fault_cnt_reg + CNT_W'(1);
  assign fire        = conv_take && trip && cnt_inc >= fq_target;
  assign mode_change = conf_wr && conf_new.alert_mode_select != conf_reg.alert_mode_select;
  assign shdn_set    = conf_wr && conf_new.power_down_select && !conf_reg.power_down_select;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_cnt_reg <= '0;
    end else if (mode_change) begin
      fault_cnt_reg <= '0;
    end else if (conv_take) begin
      fault_cnt_reg <= (fire || !trip) ? CNT_W'(0) : cnt_inc;
    end
  end

  // a trip in the cycle of a clearing read wins
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      alert_active_reg <= 1'b0;
    end else if (fire) begin
      alert_active_reg <= conf_reg.alert_mode_select ? 1'b1 : !alert_active_reg;
    end else if (mode_change) begin
      alert_active_reg <= 1'b0;
    end else if (conf_reg.alert_mode_select && (rd_access || shdn_set)) begin
      alert_active_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      expect_over_reg <= 1'b1;
    end else if (mode_change) begin
      expect_over_reg <= 1'b1;
    end else if (fire && conf_reg.alert_mode_select) begin
      expect_over_reg <= !expect_over_reg;
    end
  end

  // ****************************************
  // alert pin
  // ****************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      alert_output_oe_n <= 1'b1;
    end else if (core_ce) begin
      alert_output_oe_n <= alert_active_reg ~^ conf_reg.alert_polarity_select;
    end
  end

  assign alert_output_o = 1'b0;

  // pin readback through two flops
  logic pin_meta_reg;
  logic pin_seen_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta_reg <= 1'b1;
      pin_seen_reg <= 1'b1;
    end else if (core_ce) begin
      pin_meta_reg <= alert_output_i;
      pin_seen_reg <= pin_meta_reg;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  AST_CONF_RESET: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    $rose(reset_n) |-> conf_reg == thw_conf_s'(CONF_RST) && !alert_output_oe_n == 1'b0)
    else $error("settings not zero after reset");

  AST_TEMP_LOAD: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    conv_take |=> temp_reg == $past(conv_data_i))
    else $error("temperature not loaded at conversion end");

  AST_TEMP_READ: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    rd_access && req_hold_reg.sel == SEL_TEMP |=> rdata_reg == {$past(temp_reg), 5'h00})
    else $error("temperature read word wrong");

  AST_LIM_READ: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    rd_access && req_hold_reg.sel == SEL_OVER |=> rdata_reg[6:0] == 7'h00 && rdata_reg[15:7] == over_reg)
    else $error("set-point read word wrong");

  AST_CMP_READ_HOLD: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    rd_access && !conf_reg.alert_mode_select && !conv_take && !conf_wr |=> $stable(alert_active_reg))
    else $error("comparator alert changed by read");

  AST_INT_READ_CLR: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    rd_access && conf_reg.alert_mode_select && !fire |=> !alert_active_reg)
    else $error("interrupt alert not cleared by read");

  AST_SHDN_INT_CLR: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    shdn_set && conf_reg.alert_mode_select && !fire |=> !alert_active_reg ##1 !conv_take)
    else $error("shutdown did not clear interrupt alert");

  AST_FAULT_RUN: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    fire |-> fault_cnt_reg >= fq_target - 3'h1 && trip)
    else $error("alert moved before fault run complete");

  AST_INT_ALTERNATE: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    fire && conf_reg.alert_mode_select && !mode_change |=> expect_over_reg != $past(expect_over_reg))
    else $error("interrupt trip did not alternate");

  AST_PIN_LEVEL: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    core_ce |=> alert_output_oe_n == ($past(alert_active_reg) ~^ $past(conf_reg.alert_polarity_select)))
    else $error("alert pin level wrong");

  AST_PIN_READBACK: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    $past(core_ce) && $past(core_ce, 2) && !$past(alert_output_oe_n, 2) |-> !pin_seen_reg)
    else $error("alert pin not low while pulled");

  AST_RSP_DATA: assert property (
    @(posedge link_clk) disable iff (!reset_n)
    state_reg == LNK_WAIT && ack_pulse |=> link_rsp_valid && link_rsp_data == rdata_reg)
    else $error("link answer word wrong");

  COV_CMP_TRIP: cover property (
    @(posedge core_clk) disable iff (!reset_n) fire && !conf_reg.alert_mode_select);
  COV_INT_CLEAR: cover property (
    @(posedge core_clk) disable iff (!reset_n) alert_active_reg && rd_access && conf_reg.alert_mode_select);
  COV_FQ6: cover property (
    @(posedge core_clk) disable iff (!reset_n) fire && fq_target == FQ_CNT6);
  COV_LINK_READ: cover property (
    @(posedge link_clk) disable iff (!reset_n) link_rsp_valid && !req_hold_reg.write);
endmodule

// ### thw_pkg.sv
package thw_pkg;
  // ****************************************
  // register selection codes
  // ****************************************
  localparam logic [1:0]  SEL_TEMP     = 2'h0;
  localparam logic [1:0]  SEL_CONF     = 2'h1;
  localparam logic [1:0]  SEL_HYST     = 2'h2;
  localparam logic [1:0]  SEL_OVER     = 2'h3;

  // ****************************************
  // widths and field positions
  // ****************************************
  localparam int          TEMP_W       = 11;
  localparam int          LIM_W        = 9;
  localparam int          CNT_W        = 3;
  localparam int          TEMP_PAD_W   = 5;
  localparam int          LIM_PAD_W    = 7;
  localparam int          CONF_PAD_W   = 8;
  localparam int          CMP_DROP     = 2;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0]  CONF_RST     = 8'h00;
  localparam logic [15:0] OVER_RST     = 16'h5000;
  localparam logic [15:0] HYST_RST     = 16'h4B00;
  localparam logic [10:0] TEMP_RST     = 11'h000;

  // ****************************************
  // consecutive fault counts per code
  // ****************************************
  localparam logic [1:0]  FQ_CODE1     = 2'h0;
  localparam logic [1:0]  FQ_CODE2     = 2'h1;
  localparam logic [1:0]  FQ_CODE4     = 2'h2;
  localparam logic [2:0]  FQ_CNT1      = 3'h1;
  localparam logic [2:0]  FQ_CNT2      = 3'h2;
  localparam logic [2:0]  FQ_CNT4      = 3'h4;
  localparam logic [2:0]  FQ_CNT6      = 3'h6;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [2:0] reserved;
    logic [1:0] fault_count_select;
    logic       alert_polarity_select;
    logic       alert_mode_select;
    logic       power_down_select;
  } thw_conf_s;

  typedef struct packed {
    logic        write;
    logic [1:0]  sel;
    logic [15:0] wdata;
  } thw_req_s;

  typedef enum logic [1:0] {
    LNK_IDLE = 2'h0,
    LNK_WAIT = 2'h1,
    LNK_DONE = 2'h3
  } thw_link_e;
endpackage

// ### thw_toggle_sync.sv
module thw_toggle_sync
  import thw_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic ce,
  // toggle in, pulse out
  input  wire logic tgl_i,
  output logic      pulse_o
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else if (ce) begin
      meta_reg <= tgl_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign pulse_o = sync_reg ^ last_reg;
endmodule

// ### thw_link_host.sv
// ****************************************
// register access master on the link port
// ****************************************
module thw_link_host
  import thw_pkg::*;
(
  // link clock
  input  wire logic        link_clk,
  // request side
  output logic             link_req_valid,
  output thw_req_s         link_req,
  // answer side
  input  wire logic        link_req_ready,
  input  wire logic        link_rsp_valid,
  input  wire logic [15:0] link_rsp_data
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    link_req_valid = 1'b0;
    link_req       = '0;
  end

  // one request, held until taken, then wait for its answer
  task automatic access(input logic wr, input logic [1:0] sel, input logic [15:0] wd,
                        output logic [15:0] rd, output bit ok);
    int n;
    ok = 1'b0;
    rd = '0;
    @(negedge link_clk);
    link_req_valid = 1'b1;
    link_req = '{wr, sel, (sel == SEL_CONF) ? {3'b000, wd[12:0]} : wd};
    for (n = 0; n < 100 && !ok; n++) begin
      @(posedge link_clk);
      ok = link_req_ready;
    end
    @(negedge link_clk);
    link_req_valid = 1'b0;
    // released lines do not keep the old value
    link_req = ~link_req;
    if (!ok) return;
    ok = 1'b0;
    for (n = 0; n < 100 && !ok; n++) begin
      @(posedge link_clk);
      ok = link_rsp_valid;
    end
    // whole word taken, both bytes
    rd = link_rsp_data;
  endtask
endmodule

// ### thermal_watchdog_regs_bench.sv
module thermal_watchdog_regs_bench
  import thw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // signals
  // ****************************************
  localparam logic [10:0] HOT  = 11'h0CC;
  localparam logic [10:0] NEUT = 11'h0C8;
  localparam logic [10:0] EDGE = 11'h0CB;
  localparam logic [10:0] COLD = 11'h07C;
  logic        core_clk, link_clk, reset_n, core_ce, conv_done_i, conv_enable_o;
  logic [10:0] conv_data_i;
  logic        link_req_valid, link_req_ready, link_rsp_valid;
  thw_req_s    link_req;
  logic [15:0] link_rsp_data;
  logic        alert_output_o, alert_output_oe_n;
  wire         alert_pin;
  int          fails, samples_checked;
  int          qn[4] = '{1, 2, 4, 6};
  logic [15:0] d;

  // pull-up on the open-drain pin
  assign alert_pin = alert_output_oe_n ? 1'b1 : alert_output_o;

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7.3;
    forever #24 link_clk = ~link_clk;
  end

  thw_sensor_regs dut (
    .core_clk(core_clk), .reset_n(reset_n), .core_ce(core_ce),
    .conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .conv_enable_o(conv_enable_o),
    .link_clk(link_clk), .link_req_valid(link_req_valid), .link_req(link_req),
    .link_req_ready(link_req_ready), .link_rsp_valid(link_rsp_valid), .link_rsp_data(link_rsp_data),
    .alert_output_i(alert_pin), .alert_output_o(alert_output_o), .alert_output_oe_n(alert_output_oe_n)
  );

  thw_link_host host (
    .link_clk(link_clk), .link_req_valid(link_req_valid), .link_req(link_req),
    .link_req_ready(link_req_ready), .link_rsp_valid(link_rsp_valid), .link_rsp_data(link_rsp_data)
  );

  // ****************************************
  // tasks
  // ****************************************
  task automatic test_done;
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic wr, input logic [1:0] sel, input logic [15:0] wd);
    bit ok;
    host.access(wr, sel, wd, d, ok);
    if (!ok) begin
      fails++;
      $display("Error at %0t: link access timed out", $time);
      test_done;
    end
  endtask

  task automatic rd(input logic [1:0] sel, input logic [15:0] exp);
    xfer(1'b0, sel, 16'h0000);
    check(d, exp);
  endtask

  task automatic conv(input logic [10:0] t);
    @(negedge core_clk);
    conv_done_i = 1'b1;
    conv_data_i = t;
    @(negedge core_clk);
    conv_done_i = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask

  task automatic pin(input logic act, input logic pol);
    repeat (3) @(negedge core_clk);
    check({15'h0000, alert_pin}, {15'h0000, pol ? act : ~act});
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    reset_n     = 1'b0;
    core_ce     = 1'b1;
    conv_done_i = 1'b0;
    conv_data_i = 11'h000;
    fails           = 0;
    samples_checked = 0;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    reset_n = 1'b1;
    // reset state
    rd(SEL_CONF, 16'h0000);
    rd(SEL_OVER, 16'h5000);
    rd(SEL_HYST, 16'h4B00);
    rd(SEL_TEMP, 16'h0000);
    check({15'h0000, conv_enable_o}, 16'h0001);
    pin(1'b0, 1'b0);
    // limits 25.0 and 16.0, low bits ignored
    xfer(1'b1, SEL_OVER, 16'h197F);
    xfer(1'b1, SEL_HYST, 16'h107F);
    rd(SEL_OVER, 16'h1900);
    rd(SEL_HYST, 16'h1000);
    xfer(1'b1, SEL_TEMP, 16'hFFFF);
    rd(SEL_TEMP, 16'h0000);
    // negative value and compare boundary
    conv(11'h738);
    rd(SEL_TEMP, 16'hE700);
    conv(EDGE);
    pin(1'b0, 1'b0);
    xfer(1'b0, SEL_TEMP, 16'h0000);
    check({8'h00, d[15:8]}, {8'h00, EDGE[10:3]});
    // fault counts in comparator mode
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, SEL_CONF, {3'b000, k[1:0], k[0], 10'h000});
      rd(SEL_CONF, {3'b000, k[1:0], k[0], 10'h000});
      repeat (qn[k] - 1) conv(HOT);
      conv(NEUT);
      repeat (qn[k] - 1) conv(HOT);
      pin(1'b0, k[0]);
      conv(HOT);
      pin(1'b1, k[0]);
      rd(SEL_TEMP, {HOT, 5'h00});
      pin(1'b1, k[0]);
      repeat (qn[k]) conv(COLD);
      pin(1'b0, k[0]);
    end
    // shutdown in comparator mode
    xfer(1'b1, SEL_CONF, 16'h0000);
    conv(HOT);
    pin(1'b1, 1'b0);
    xfer(1'b1, SEL_CONF, 16'h0100);
    check({15'h0000, conv_enable_o}, 16'h0000);
    pin(1'b1, 1'b0);
    conv(COLD);
    rd(SEL_TEMP, {HOT, 5'h00});
    xfer(1'b1, SEL_CONF, 16'h0000);
    core_ce = 1'b0;
    conv(COLD);
    core_ce = 1'b1;
    rd(SEL_TEMP, {HOT, 5'h00});
    conv(COLD);
    pin(1'b0, 1'b0);
    // interrupt mode
    xfer(1'b1, SEL_CONF, 16'h0200);
    conv(COLD);
    pin(1'b0, 1'b0);
    conv(HOT);
    conv(HOT);
    pin(1'b1, 1'b0);
    rd(SEL_CONF, 16'h0200);
    pin(1'b0, 1'b0);
    conv(HOT);
    pin(1'b0, 1'b0);
    conv(COLD);
    pin(1'b1, 1'b0);
    rd(SEL_HYST, 16'h1000);
    pin(1'b0, 1'b0);
    conv(HOT);
    pin(1'b1, 1'b0);
    xfer(1'b1, SEL_CONF, 16'h0300);
    pin(1'b0, 1'b0);
    // reset in mid-run restores the defaults
    reset_n = 1'b0;
    repeat (3) @(negedge core_clk);
    check({15'h0000, conv_enable_o}, 16'h0001);
    reset_n = 1'b1;
    rd(SEL_CONF, 16'h0000);
    rd(SEL_HYST, 16'h4B00);
    rd(SEL_TEMP, 16'h0000);
    pin(1'b0, 1'b0);
    test_done;
  end
endmodule
